// ===== rtl/global_ctrl_consts.vh
/*
  Offsets, field positions, reset values and timing counts of the global
  control register bank. Included by the bank module only.
*/
`ifndef GLOBAL_CTRL_CONSTS_VH
`define GLOBAL_CTRL_CONSTS_VH

`define GC_ADDR_PAGE 8'h00
`define GC_ADDR_SRST 8'h01
`define GC_ADDR_REFCFG 8'h02
`define GC_ADDR_SUPPLY 8'h03
`define GC_ADDR_MISC 8'h04
`define GC_ADDR_IRQ_STS 8'h08
`define GC_ADDR_IRQ_MSK 8'h09

`define GC_RST_PAGE 8'h00
`define GC_RST_REFCFG 8'h00
`define GC_RST_SUPPLY_WAKE 1'b0
`define GC_RST_MISC 8'h00
`define GC_RST_IRQ 3'h0

`define GC_BIT_SRST 0
`define GC_QCHG_HI 5
`define GC_QCHG_LO 4
`define GC_BIT_SLEEP_EXIT 3
`define GC_BIT_ANA_MODE 2
`define GC_BIT_IO_MODE 1
`define GC_BIT_AWAKE 0
`define GC_BIT_ANA_FLAG 7
`define GC_BIT_IO_FLAG 6
`define GC_BIT_LOW_FLAG 1
`define GC_BIT_LOW_WAKE 0
`define GC_BIT_IGN_CLK 6
`define GC_BIT_BCAST 1

// Charge times in microseconds; counts derived at 100 MHz
`define GC_CLK_MHZ 100
`define GC_QCHG0_US 3500
`define GC_QCHG1_US 10000
`define GC_QCHG2_US 50000
`define GC_QCHG3_US 100000
`define GC_QCHG0_CYC (`GC_QCHG0_US * `GC_CLK_MHZ)
`define GC_QCHG1_CYC (`GC_QCHG1_US * `GC_CLK_MHZ)
`define GC_QCHG2_CYC (`GC_QCHG2_US * `GC_CLK_MHZ)
`define GC_QCHG3_CYC (`GC_QCHG3_US * `GC_CLK_MHZ)

`endif

// ===== rtl/global_ctrl_regs.v
/*
  Global control and status register bank: page select, software reset,
  reference quick-charge timer, sleep control, supply modes with forced
  overrides, low-supply shutdown status, clock-error action, broadcast
  addressing and a small interrupt block.
  Assumes a one-clock register port (read data one cycle after the read
  strobe) and supply/shutdown/clock-error indications from analog logic
  in other domains, synchronised here.
*/
// Chosen here: the plain strobed port.
`include "global_ctrl_consts.vh"

module global_ctrl_regs #(
  parameter [31:0] QCHG0_CYC = `GC_QCHG0_CYC,
  parameter [31:0] QCHG1_CYC = `GC_QCHG1_CYC,
  parameter [31:0] QCHG2_CYC = `GC_QCHG2_CYC,
  parameter [31:0] QCHG3_CYC = `GC_QCHG3_CYC
) (
  input wire i_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_ana_high,
  input wire i_io_high,
  input wire i_low_shutdown,
  input wire i_clk_err,
  output reg [7:0] o_page,
  output reg o_awake,
  output reg o_dig_reg_en,
  output reg o_ref_en,
  output reg o_ref_qchg,
  output reg o_ana_direct,
  output reg o_io_low_only,
  output reg o_clk_shutdown,
  output reg o_bcast_en,
  output reg o_irq
);

  reg [7:0] page_q;
  reg [7:0] refcfg_q;
  reg low_wake_q;
  reg [7:0] misc_q;
  reg [2:0] irq_sts_q;
  reg [2:0] irq_msk_q;
  reg [1:0] ana_s_q, io_s_q, low_s_q, cerr_s_q;
  reg low_prev_q, cerr_prev_q, sleep_prev_q;
  reg [31:0] qchg_cnt_q;
  reg low_latch_q;
  reg srst_q;
  reg [7:0] rd_d;
  reg [31:0] qchg_len;
  wire ana_flag, io_flag, low_flag, cerr;
  wire low_rise, cerr_rise, wake_edge, awake_eff;
  wire [2:0] irq_ev;
  wire clr;

  // Detector inputs come from other domains
  always @(posedge i_clk) begin
    if (i_rst) begin
      ana_s_q <= 2'h0;
      io_s_q <= 2'h0;
      low_s_q <= 2'h0;
      cerr_s_q <= 2'h0;
    end else begin
      ana_s_q <= {ana_s_q[0], i_ana_high};
      io_s_q <= {io_s_q[0], i_io_high};
      low_s_q <= {low_s_q[0], i_low_shutdown};
      cerr_s_q <= {cerr_s_q[0], i_clk_err};
    end
  end

  assign ana_flag = ana_s_q[1];
  assign io_flag = io_s_q[1];
  assign low_flag = low_s_q[1];
  assign cerr = cerr_s_q[1];
  assign low_rise = low_flag & ~low_prev_q;
  assign cerr_rise = cerr & ~cerr_prev_q;

  assign clr = i_rst | srst_q;

  // A shutdown latches until the host writes the awake bit again
  // wake option after shutdown
  assign awake_eff = refcfg_q[`GC_BIT_AWAKE] &
                     ~(low_latch_q & ~low_wake_q) &
                     ~(cerr & ~misc_q[`GC_BIT_IGN_CLK]);
  assign wake_edge = awake_eff & ~sleep_prev_q;
  assign irq_ev = {cerr_rise, low_rise, wake_edge};

  always @* begin
    case (refcfg_q[`GC_QCHG_HI:`GC_QCHG_LO])
      2'h0: qchg_len = QCHG0_CYC;
      2'h1: qchg_len = QCHG1_CYC;
      2'h2: qchg_len = QCHG2_CYC;
      default: qchg_len = QCHG3_CYC;
    endcase
  end

  always @(posedge i_clk) begin
    if (clr) begin
      page_q <= `GC_RST_PAGE;
      refcfg_q <= `GC_RST_REFCFG;
      low_wake_q <= `GC_RST_SUPPLY_WAKE;
      misc_q <= `GC_RST_MISC;
      irq_msk_q <= `GC_RST_IRQ;
      low_latch_q <= 1'b0;
    end else begin
      if (i_wr) begin
        case (i_addr)
          `GC_ADDR_PAGE: page_q <= i_wdata;
          `GC_ADDR_REFCFG: refcfg_q <= i_wdata;
          `GC_ADDR_SUPPLY: low_wake_q <= i_wdata[`GC_BIT_LOW_WAKE];
          `GC_ADDR_MISC: misc_q <= i_wdata;
          `GC_ADDR_IRQ_MSK: irq_msk_q <= i_wdata[2:0];
          default: ;
        endcase
      end
      // shutdown seen; cleared by rewriting awake
      if (low_rise)
        low_latch_q <= 1'b1;
      else if (i_wr && i_addr == `GC_ADDR_REFCFG && i_wdata[`GC_BIT_AWAKE])
        low_latch_q <= 1'b0;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst)
      srst_q <= 1'b0;
    else
      srst_q <= i_wr && i_addr == `GC_ADDR_SRST && i_wdata[`GC_BIT_SRST] && !srst_q;
  end

  // Status: set wins over the read clear
  always @(posedge i_clk) begin
    if (clr)
      irq_sts_q <= `GC_RST_IRQ;
    else if (i_rd && i_addr == `GC_ADDR_IRQ_STS)
      irq_sts_q <= irq_ev;
    else
      irq_sts_q <= irq_sts_q | irq_ev;
  end

  // Edge history survives a soft reset, else a still-high detector looks like a new event
  always @(posedge i_clk) begin
    if (i_rst) begin
      low_prev_q <= 1'b0;
      cerr_prev_q <= 1'b0;
    end else begin
      low_prev_q <= low_flag;
      cerr_prev_q <= cerr;
    end
  end

  // quick-charge timer restarts at each wake
  always @(posedge i_clk) begin
    if (clr) begin
      qchg_cnt_q <= 32'h0;
      sleep_prev_q <= 1'b0;
    end else begin
      sleep_prev_q <= awake_eff;
      if (wake_edge)
        qchg_cnt_q <= qchg_len;
      else if (!awake_eff)
        qchg_cnt_q <= 32'h0;
      else if (qchg_cnt_q != 32'h0)
        qchg_cnt_q <= qchg_cnt_q - 32'h1;
    end
  end

  always @* begin
    rd_d = 8'h00;
    case (i_addr)
      `GC_ADDR_PAGE: rd_d = page_q;
      `GC_ADDR_SRST: rd_d = 8'h00;
      `GC_ADDR_REFCFG: rd_d = refcfg_q;
      `GC_ADDR_SUPPLY: rd_d = {ana_flag, io_flag, 4'h0, low_latch_q, low_wake_q};
      `GC_ADDR_MISC: rd_d = misc_q;
      `GC_ADDR_IRQ_STS: rd_d = {5'h00, irq_sts_q};
      `GC_ADDR_IRQ_MSK: rd_d = {5'h00, irq_msk_q};
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_page <= `GC_RST_PAGE;
      o_awake <= 1'b0;
      o_dig_reg_en <= 1'b0;
      o_ref_en <= 1'b0;
      o_ref_qchg <= 1'b0;
      o_ana_direct <= 1'b0;
      o_io_low_only <= 1'b0;
      o_clk_shutdown <= 1'b0;
      o_bcast_en <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_d : 8'h00;
      o_page <= page_q;
      o_awake <= awake_eff;
      o_dig_reg_en <= awake_eff;
      o_ref_en <= awake_eff & refcfg_q[`GC_BIT_SLEEP_EXIT];
      o_ref_qchg <= awake_eff & refcfg_q[`GC_BIT_SLEEP_EXIT] & (qchg_cnt_q != 32'h0);
      o_ana_direct <= refcfg_q[`GC_BIT_ANA_MODE] & ~ana_flag;
      o_io_low_only <= refcfg_q[`GC_BIT_IO_MODE] & ~io_flag;
      o_clk_shutdown <= cerr & ~misc_q[`GC_BIT_IGN_CLK];
      o_bcast_en <= misc_q[`GC_BIT_BCAST];
      o_irq <= |(irq_sts_q & irq_msk_q);
    end
  end

endmodule // global_ctrl_regs

// ===== test/ctrl_host.sv
/* Host model driving the bank register port.
   Assumes i_clk is the bank clock. */
module ctrl_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_addr, o_wdata, o_wr, o_rd} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    // Released lines must not keep the last value
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
endmodule // ctrl_host

// ===== test/gc_checker.sv
/* Port assertions of the control bank.
   Assumes one clock and a synchronous high reset. */
module gc_checker (
  input logic i_clk, i_rst, i_wr, i_rd, i_ana_high, i_io_high,
  input logic [7:0] i_addr, i_wdata, o_rdata, o_page,
  input logic o_awake, o_dig_reg_en, o_ref_en, o_ana_direct, o_io_low_only, o_bcast_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_srst; i_wr && i_addr == 8'h01 && i_wdata[0]; endsequence
  sequence s_ana_hi; i_ana_high [*6]; endsequence
  sequence s_io_hi; i_io_high [*6]; endsequence
  a_page_write: assert property (i_wr && i_addr == 8'h00 |-> ##2 o_page == $past(i_wdata, 2))
    else $error("page output wrong");
  a_srst_clear: assert property (s_srst |-> ##3 o_page == 8'h00 && !o_bcast_en)
    else $error("soft reset left state");
  a_regulator_awake: assert property (o_dig_reg_en == o_awake)
    else $error("regulator not tied to awake");
  a_ref_gate: assert property (o_ref_en |-> o_awake)
    else $error("reference on while asleep");
  a_ana_force: assert property (s_ana_hi |=> !o_ana_direct)
    else $error("analog mode not forced");
  a_io_force: assert property (s_io_hi |=> !o_io_low_only)
    else $error("io mode not forced");
  a_bcast_write: assert property (i_wr && i_addr == 8'h04 |-> ##2
    {7'h0, o_bcast_en} == ($past(i_wdata, 2) & 8'h02) >> 1)
    else $error("broadcast output wrong");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule // gc_checker
bind global_ctrl_regs gc_checker u_chk (.i_clk, .i_rst, .i_wr, .i_rd, .i_ana_high, .i_io_high,
  .i_addr, .i_wdata, .o_rdata, .o_page, .o_awake, .o_dig_reg_en, .o_ref_en, .o_ana_direct,
  .o_io_low_only, .o_bcast_en);

// ===== test/global_ctrl_regs_tb.sv
/* Directed bench of the control bank with a host model.
   Assumes the short charge counts set at the instance. */
module global_ctrl_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, ana = 0, io = 0, lsd = 0, cerr = 0;
  logic [7:0] addr, wdata, rdata, page, v, e;
  logic wr, rd, awake, digital_regulator, refe, qchg, adir, iolo, cshut, bcast, irq;
  int error_cnt = 0, samples_checked = 0, n;
  int qc[4] = '{5, 10, 20, 40};
  always #5 clk = ~clk;
  ctrl_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd));
  global_ctrl_regs #(.QCHG0_CYC(5), .QCHG1_CYC(10), .QCHG2_CYC(20), .QCHG3_CYC(40)) DUT (
    .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_ana_high(ana), .i_io_high(io), .i_low_shutdown(lsd), .i_clk_err(cerr),
    .o_page(page), .o_awake(awake), .o_dig_reg_en(digital_regulator), .o_ref_en(refe), .o_ref_qchg(qchg),
    .o_ana_direct(adir), .o_io_low_only(iolo), .o_clk_shutdown(cshut), .o_bcast_en(bcast),
    .o_irq(irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, v);
    chk(v, exp);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++) rdc(a[7:0], 8'h00);
    chk(8'(awake), 8'h00);
    $display("reset defaults done");
    for (int p = 0; p < 256; p += 85) begin
      host.wr(8'h00, p[7:0]);
      idle(2);
      chk(page, p[7:0]);
      rdc(8'h00, p[7:0]);
    end
    $display("page select done");
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h02, 8'h00);
      e = {2'b00, c[1:0], 1'b1, c[0], c[1], 1'b1};
      host.wr(8'h02, e);
      n = 0;
      repeat (60) begin
        @(posedge clk);
        #1 n += qchg;
      end
      chk(n[7:0], qc[c][7:0]);
      chk(8'({awake, digital_regulator, refe, adir, iolo}), 8'({3'h7, c[0], c[1]}));
      rdc(8'h02, e);
    end
    host.wr(8'h02, 8'h01);
    idle(2);
    chk(8'({digital_regulator, refe}), 8'h02);
    $display("reference and sleep done");
    host.wr(8'h02, 8'h07);
    @(posedge clk) {ana, io} <= 2'b11;
    idle(8);
    chk(8'({adir, iolo}), 8'h00);
    rdc(8'h03, 8'hc0);
    @(posedge clk) {ana, io} <= 2'b00;
    idle(8);
    chk(8'({adir, iolo}), 8'h03);
    $display("supply override done");
    host.rd(8'h08, v);
    @(posedge clk) lsd <= 1'b1;
    idle(8);
    chk(8'({awake, irq}), 8'h00);
    rdc(8'h03, 8'h02);
    host.wr(8'h09, 8'h02);
    idle(2);
    chk(8'(irq), 8'h01);
    rdc(8'h08, 8'h02);
    idle(2);
    chk(8'(irq), 8'h00);
    host.wr(8'h03, 8'h01);
    @(posedge clk) lsd <= 1'b0;
    host.wr(8'h02, 8'h01);
    @(posedge clk) lsd <= 1'b1;
    idle(8);
    chk(8'(awake), 8'h01);
    rdc(8'h03, 8'h03);
    $display("low supply and irq done");
    @(posedge clk) cerr <= 1'b1;
    idle(8);
    chk(8'(cshut), 8'h01);
    host.wr(8'h04, 8'h42);
    idle(8);
    chk(8'({cshut, bcast}), 8'h01);
    rdc(8'h04, 8'h42);
    $display("clock error and broadcast done");
    host.wr(8'h00, 8'h5a);
    host.wr(8'h01, 8'h01);
    idle(3);
    chk(page, 8'h00);
    rdc(8'h01, 8'h00);
    rdc(8'h04, 8'h00);
    $display("soft reset done");
    conclude();
  end
endmodule // global_ctrl_regs_tb
